//--- hdl/rtc_defs.vh
`ifndef RTC_DEFS_VH
`define RTC_DEFS_VH
// Register addresses on the serial link
`define RTC_ADDR_SEC     4'h0
`define RTC_ADDR_ADJ     4'h7
`define RTC_ADDR_CTRL1   4'hE
`define RTC_ADDR_CTRL2   4'hF
// Control one field positions
`define RTC_C1_WALE      7
`define RTC_C1_DALE      6
`define RTC_C1_H24       5
`define RTC_C1_CLKOFF_A  4
`define RTC_C1_TEST      3
// Control/status two field positions
`define RTC_C2_VSEL      7
`define RTC_C2_VFLAG     6
`define RTC_C2_SPARE1    5
`define RTC_C2_HALT      4
`define RTC_C2_CLKOFF_B  3
`define RTC_C2_PFLAG     2
`define RTC_C2_WFLAG     1
`define RTC_C2_DFLAG     0
// Reset values
`define RTC_CTRL1_RST    8'h00
`define RTC_CTRL2_RST    8'h10
`define RTC_ADJ_RST      7'h00
// Command byte read bit
`define RTC_CMD_READ     3
// Periodic select codes
`define RTC_PS_OFF       3'h0
`define RTC_PS_LOW       3'h1
`define RTC_PS_2HZ       3'h2
`define RTC_PS_1HZ       3'h3
`define RTC_PS_SEC       3'h4
`define RTC_PS_MIN       3'h5
`define RTC_PS_HOUR      3'h6
`define RTC_PS_MONTH     3'h7
// Timing
`define RTC_CLK_NS       10
`define RTC_INC_DELAY_NS 92000
`define RTC_OSC_PER_SEC  32768
`endif

//--- hdl/rtc_ctl.v
// Function
// - Either clock-off bit low drives slow clock
// - Both clock-off bits high hold pin off
// - Ungated variant: clock-off bits are scratch
// - Codes 0-3: off, low, 2Hz, 1Hz
// - Codes 4-7: second/minute/hour/month level interrupts
// - Seconds increment lags pulse fall 92us
// - Seconds write resets divider, drives pulse low
// - Level interrupt falls with seconds increment
// - Adjustment may stretch or shrink cycle
// - Threshold select: 0 is 2.1V, 1 is 1.6V
// - Low supply sets sticky flag, halts monitor
// - Writing zero clears flag, restarts monitor
// - Spare bit one read/write, cleared on halt
// - Halt sensing only while chip enable low
// - Halt flag sticky, defaults to one
// - Halt flag clears adjustment and control bits
// - Writing zero clears halt flag
// - Control two layout at F, reset 10h
// - Level mode: writing zero releases interrupt
// - Control one lives at address E
`timescale 1ns/100ps
`include "rtc_defs.vh"
module rtc_ctl
#(
  parameter GATEABLE  = 1,
  parameter DIV_W     = 15,
  parameter OSC_PER_S = `RTC_OSC_PER_SEC,
  parameter INC_DELAY = `RTC_INC_DELAY_NS / `RTC_CLK_NS
)
(
  input  wire       clk,
  input  wire       rst,
  input  wire       ce,
  input  wire       sclk,
  input  wire       si,
  output wire       so_o,
  output wire       so_oe,
  input  wire       osc_in,
  input  wire       osc_stopped,
  input  wire       supply_below_hi,
  input  wire       supply_below_lo,
  input  wire       adj_stretch,
  input  wire       adj_shrink,
  input  wire       wrap_min,
  input  wire       wrap_hour,
  input  wire       wrap_month,
  input  wire       alarm_w_hit,
  input  wire       alarm_d_hit,
  input  wire [7:0] ext_rd_data,
  output reg        reg_wr_stb_q,
  output reg  [3:0] reg_wr_addr_q,
  output reg  [7:0] reg_wr_data_q,
  output reg        sec_inc_q,
  output wire [6:0] adj_value,
  output wire       alarm_w_en,
  output wire       alarm_d_en,
  output wire       hour_mode_24,
  output wire       test_mode,
  output wire       slow_clock_out_o,
  output wire       slow_clock_out_oe,
  output wire       irq_out_n_o,
  output wire       irq_out_n_oe
);

  // Full-width forms first, then cut to the counter widths on purpose
  localparam integer     DIV_LAST_I = OSC_PER_S - 1;
  localparam integer     DIV_HALF_I = OSC_PER_S / 2;
  localparam integer     DIV_QTR_I  = OSC_PER_S / 4;
  localparam integer     DLY_LAST_I = INC_DELAY - 1;
  localparam [DIV_W-1:0] DIV_LAST   = DIV_LAST_I[DIV_W-1:0];
  localparam [DIV_W-1:0] DIV_HALF   = DIV_HALF_I[DIV_W-1:0];
  localparam [DIV_W-1:0] DIV_QTR    = DIV_QTR_I[DIV_W-1:0];
  localparam [15:0]      DLY_LAST   = DLY_LAST_I[15:0];
  localparam [7:0]       CTRL2_RST  = `RTC_CTRL2_RST;

  // Synchronisers for every pin input
  reg  [6:0]       s1_q;            // first stage, read by s2 only
  reg  [6:0]       s2_q;            // settled copies
  reg              sclk_prev_q;     // for edge finding
  reg              osc_prev_q;
  wire             ce_s      = s2_q[0];
  wire             sclk_s    = s2_q[1];
  wire             si_s      = s2_q[2];
  wire             osc_s     = s2_q[3];
  wire             stop_s    = s2_q[4];
  wire             below_hi  = s2_q[5];
  wire             below_lo  = s2_q[6];
  wire             sclk_rise = sclk_s & ~sclk_prev_q;
  wire             osc_rise  = osc_s & ~osc_prev_q;

  // Serial engine state
  reg  [2:0]       bitcnt_q;        // bit within byte
  reg  [6:0]       shin_q;          // incoming bits
  reg  [7:0]       shout_q;         // outgoing byte, msb first
  reg  [3:0]       addr_q;          // current register address
  reg              rd_q;            // read transfer
  reg              cmd_done_q;      // command byte taken
  wire [7:0]       byte_now  = {shin_q, si_s};
  wire             byte_end  = ce_s & sclk_rise & (bitcnt_q == 3'h7);
  wire             wr_hit    = byte_end & cmd_done_q & ~rd_q;

  // Register contents
  reg  [7:0]       ctrl1_q;         // control one
  reg  [6:0]       adj_q;           // adjustment register
  reg              vsel_q;
  reg              vflag_q;
  reg              spare1_q;
  reg              halt_q;
  reg              clkoff_b_q;
  reg              lvl_q;           // level-mode interrupt held
  reg              wflag_q;
  reg              dflag_q;

  // Timebase
  reg  [DIV_W-1:0] div_q;           // sub-second divider
  reg  [15:0]      dly_q;           // increment delay count
  reg              dly_run_q;
  reg              clk_oe_q;        // slow clock pull-down
  reg              irq_q;           // interrupt pin low

  wire [2:0]       psel      = ctrl1_q[2:0];
  wire             wr_c1     = wr_hit & (addr_q == `RTC_ADDR_CTRL1);
  wire             wr_c2     = wr_hit & (addr_q == `RTC_ADDR_CTRL2);
  wire             wr_adj    = wr_hit & (addr_q == `RTC_ADDR_ADJ);
  wire             wr_sec    = wr_hit & (addr_q == `RTC_ADDR_SEC);
  wire             pulse_lo;
  wire             periodic_irq_flag_rd;
  wire             sec_inc_now = dly_run_q & (dly_q == DLY_LAST);

  // Shared low phase: first half of each second or half-second
  assign pulse_lo = (psel == `RTC_PS_1HZ) ? (div_q < DIV_HALF) :
                    ((div_q % DIV_HALF) < DIV_QTR);

  // Periodic flag as read: follows the periodic part of the pin drive, without the alarm flags, in non-level modes
  assign periodic_irq_flag_rd  = psel[2] ? lvl_q :
                    (psel == `RTC_PS_LOW) ? 1'b1 :
                    (psel == `RTC_PS_OFF) ? 1'b0 : pulse_lo;

  // Read data for one address
  function [7:0] rd_mux;
    input [3:0] a;
    begin
      case (a)
        `RTC_ADDR_ADJ:   rd_mux = {1'b0, adj_q};
        `RTC_ADDR_CTRL1: rd_mux = ctrl1_q;
        `RTC_ADDR_CTRL2: rd_mux = {vsel_q, vflag_q, spare1_q, halt_q,
                                   clkoff_b_q, periodic_irq_flag_rd, wflag_q, dflag_q};
        default:         rd_mux = ext_rd_data;
      endcase
    end
  endfunction

  // Two-stage sampling of all pins
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s1_q        <= 7'h00;
      s2_q        <= 7'h00;
      sclk_prev_q <= 1'b0;
      osc_prev_q  <= 1'b0;
    end
    else
    begin
      s1_q        <= {supply_below_lo, supply_below_hi, osc_stopped,
                      osc_in, si, sclk, ce};
      s2_q        <= s1_q;
      sclk_prev_q <= sclk_s;
      osc_prev_q  <= osc_s;
    end
  end

  // Serial engine: command byte then data bytes, address auto-increments
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      bitcnt_q      <= 3'h0;
      shin_q        <= 7'h00;
      shout_q       <= 8'h00;
      addr_q        <= 4'h0;
      rd_q          <= 1'b0;
      cmd_done_q    <= 1'b0;
      reg_wr_stb_q  <= 1'b0;
      reg_wr_addr_q <= 4'h0;
      reg_wr_data_q <= 8'h00;
    end
    else
    begin
      reg_wr_stb_q <= 1'b0;
      if (!ce_s)
      begin
        // Frame over, start clean next time
        bitcnt_q   <= 3'h0;
        cmd_done_q <= 1'b0;
        rd_q       <= 1'b0;
      end
      else if (sclk_rise)
      begin
        bitcnt_q <= bitcnt_q + 3'h1;
        shin_q   <= byte_now[6:0];
        shout_q  <= {shout_q[6:0], 1'b0};
        if (bitcnt_q == 3'h7)
        begin
          if (!cmd_done_q)
          begin
            // Command: address high nibble, read flag
            cmd_done_q <= 1'b1;
            addr_q     <= byte_now[7:4];
            rd_q       <= byte_now[`RTC_CMD_READ];
            shout_q    <= rd_mux(byte_now[7:4]);
          end
          else
          begin
            addr_q  <= addr_q + 4'h1;
            shout_q <= rd_mux(addr_q + 4'h1);
            if (!rd_q)
            begin
              // Mirror every write to the outer counters
              reg_wr_stb_q  <= 1'b1;
              reg_wr_addr_q <= addr_q;
              reg_wr_data_q <= byte_now;
            end
          end
        end
      end
    end
  end

  assign so_o  = shout_q[7];
  assign so_oe = ce_s & cmd_done_q & rd_q;

  // Control and status bits
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl1_q    <= `RTC_CTRL1_RST;
      adj_q      <= `RTC_ADJ_RST;
      vsel_q     <= CTRL2_RST[`RTC_C2_VSEL];
      vflag_q    <= 1'b0;
      spare1_q   <= 1'b0;
      halt_q     <= 1'b1;
      clkoff_b_q <= 1'b0;
      lvl_q      <= 1'b0;
      wflag_q    <= 1'b0;
      dflag_q    <= 1'b0;
    end
    else
    begin
      // Halt sensing, gated by chip enable; set beats clear
      if (stop_s && !ce_s)
        halt_q <= 1'b1;
      else if (wr_c2 && !byte_now[`RTC_C2_HALT])
        halt_q <= 1'b0;
      if (halt_q)
      begin
        // Everything but the halt flag held at zero
        ctrl1_q    <= 8'h00;
        adj_q      <= 7'h00;
        vsel_q     <= 1'b0;
        vflag_q    <= 1'b0;
        spare1_q   <= 1'b0;
        clkoff_b_q <= 1'b0;
        lvl_q      <= 1'b0;
        wflag_q    <= 1'b0;
        dflag_q    <= 1'b0;
      end
      else
      begin
        if (wr_c1)
          ctrl1_q <= byte_now;
        if (wr_adj)
          adj_q <= byte_now[6:0];
        if (wr_c2)
        begin
          vsel_q     <= byte_now[`RTC_C2_VSEL];
          spare1_q   <= byte_now[`RTC_C2_SPARE1];
          clkoff_b_q <= byte_now[`RTC_C2_CLKOFF_B];
        end
        // Monitor runs only while the flag is clear
        if (!vflag_q && (vsel_q ? below_lo : below_hi))
          vflag_q <= 1'b1;
        else if (wr_c2 && !byte_now[`RTC_C2_VFLAG])
          vflag_q <= 1'b0;
        // Level interrupt, set wins over software clear
        if (!psel[2])
          lvl_q <= 1'b0;
        else if (sec_inc_now && (psel == `RTC_PS_SEC ||
                 (psel == `RTC_PS_MIN && wrap_min) ||
                 (psel == `RTC_PS_HOUR && wrap_hour) ||
                 (psel == `RTC_PS_MONTH && wrap_month)))
          lvl_q <= 1'b1;
        else if (wr_c2 && !byte_now[`RTC_C2_PFLAG])
          lvl_q <= 1'b0;
        // Alarm flags read zero while their alarm is disabled
        if (!ctrl1_q[`RTC_C1_WALE])
          wflag_q <= 1'b0;
        else if (alarm_w_hit)
          wflag_q <= 1'b1;
        else if (wr_c2 && !byte_now[`RTC_C2_WFLAG])
          wflag_q <= 1'b0;
        if (!ctrl1_q[`RTC_C1_DALE])
          dflag_q <= 1'b0;
        else if (alarm_d_hit)
          dflag_q <= 1'b1;
        else if (wr_c2 && !byte_now[`RTC_C2_DFLAG])
          dflag_q <= 1'b0;
      end
    end
  end

  // Divider on oscillator edges; seconds write restarts it
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      div_q     <= {DIV_W{1'b0}};
      dly_q     <= 16'h0000;
      dly_run_q <= 1'b0;
      sec_inc_q <= 1'b0;
    end
    else
    begin
      sec_inc_q <= sec_inc_now;
      if (wr_sec)
      begin
        div_q     <= {DIV_W{1'b0}};
        dly_run_q <= 1'b0;
      end
      else
      begin
        if (osc_rise)
        begin
          // Stretch skips a count, shrink takes two
          if (adj_stretch)
            div_q <= div_q;
          else if (div_q == DIV_LAST)
            div_q <= {DIV_W{1'b0}};
          else if (adj_shrink && div_q != DIV_LAST - 1'b1)
            div_q <= div_q + 2'h2;
          else
            div_q <= div_q + 1'b1;
        end
        // Pulse falls at wrap; increment lands after the delay
        if (osc_rise && div_q == DIV_LAST && !adj_stretch)
        begin
          dly_run_q <= 1'b1;
          dly_q     <= 16'h0000;
        end
        else if (dly_run_q)
        begin
          dly_q <= dly_q + 16'h0001;
          if (dly_q == DLY_LAST)
            dly_run_q <= 1'b0;
        end
      end
    end
  end

  // Pin drivers from flops; both pins are open drain
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      clk_oe_q <= 1'b0;
      irq_q    <= 1'b0;
    end
    else
    begin
      // Two-register gating guards against a runaway host
      if (GATEABLE != 0 && ctrl1_q[`RTC_C1_CLKOFF_A] && clkoff_b_q)
        clk_oe_q <= 1'b0;
      else
        clk_oe_q <= ~osc_s;
      case (psel)
        `RTC_PS_OFF: irq_q <= wflag_q | dflag_q;
        `RTC_PS_LOW: irq_q <= 1'b1;
        `RTC_PS_2HZ: irq_q <= pulse_lo | wflag_q | dflag_q;
        `RTC_PS_1HZ: irq_q <= pulse_lo | wflag_q | dflag_q;
        default:     irq_q <= lvl_q | wflag_q | dflag_q;
      endcase
    end
  end

  assign slow_clock_out_o  = 1'b0;
  assign slow_clock_out_oe = clk_oe_q;
  assign irq_out_n_o       = 1'b0;
  assign irq_out_n_oe      = irq_q;
  assign adj_value         = adj_q;
  assign alarm_w_en        = ctrl1_q[`RTC_C1_WALE];
  assign alarm_d_en        = ctrl1_q[`RTC_C1_DALE];
  assign hour_mode_24      = ctrl1_q[`RTC_C1_H24];
  assign test_mode         = ctrl1_q[`RTC_C1_TEST];

endmodule

//--- tb/rtc_ctl_checker.sv
`timescale 1ns/100ps
module rtc_ctl_checker
#(
  parameter GATEABLE = 1
)
(
  input wire       clk,
  input wire       rst,
  input wire       ce,
  input wire       osc_in,
  input wire       osc_stopped,
  input wire       reg_wr_stb_q,
  input wire [3:0] reg_wr_addr_q,
  input wire [7:0] reg_wr_data_q,
  input wire       sec_inc_q,
  input wire [6:0] adj_value,
  input wire       test_mode,
  input wire       slow_clock_out_oe,
  input wire       irq_out_n_oe
);
  reg  [2:0] mode_q;   // Shadow of the periodic select field
  reg        gate_a_q; // Shadow of clock-off bit a
  reg        gate_b_q; // Shadow of clock-off bit b
  reg        halt_q;   // Shadow of the halt flag
  reg  [3:0] quiet_q;  // Cycles since the last write or halt, saturating
  wire       wr_e  = reg_wr_stb_q && reg_wr_addr_q == 4'hE && !halt_q;
  wire       wr_f  = reg_wr_stb_q && reg_wr_addr_q == 4'hF;
  wire       stop  = osc_stopped && !ce;
  wire       gated = GATEABLE != 0 && gate_a_q && gate_b_q;
  // Shadow rebuilt from write strobes; quiet masks sync latency after changes
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      {mode_q, gate_a_q, gate_b_q, halt_q, quiet_q} <= 10'h010;
    else if (stop)
      {mode_q, gate_a_q, gate_b_q, halt_q, quiet_q} <= 10'h010;
    else
    begin
      quiet_q <= reg_wr_stb_q ? 4'h0 : quiet_q + {3'h0, quiet_q != 4'hF};
      if (wr_e)
        {mode_q, gate_a_q} <= {reg_wr_data_q[2:0], reg_wr_data_q[4]};
      if (wr_f && halt_q)
        halt_q <= reg_wr_data_q[4];
      if (wr_f && !halt_q)
        gate_b_q <= reg_wr_data_q[3];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_reset_clears: assert property ($fell(rst) |-> adj_value == 7'h00 && !test_mode)
    else $error("control bits not cleared after reset");
  a_irq_off: assert property (quiet_q > 4'h2 && mode_q == 3'h0 |-> !irq_out_n_oe)
    else $error("interrupt asserted with periodic output off");
  a_irq_fixed_low: assert property (quiet_q > 4'h2 && mode_q == 3'h1 |-> irq_out_n_oe)
    else $error("interrupt not held in fixed low code");
  a_level_on_inc: assert property (mode_q == 3'h4 && quiet_q > 4'h2 && sec_inc_q
    |=> irq_out_n_oe)
    else $error("seconds level interrupt missing after increment");
  a_level_rise_cause: assert property ($rose(irq_out_n_oe) && mode_q[2] && quiet_q > 4'h3
    |-> $past(sec_inc_q))
    else $error("level interrupt not aligned to seconds increment");
  a_level_release: assert property (wr_f && !halt_q && mode_q[2] && !reg_wr_data_q[2]
    |=> ##1 !irq_out_n_oe)
    else $error("level interrupt not released by flag clear");
  a_pulse_restart: assert property (reg_wr_stb_q && reg_wr_addr_q == 4'h0
    && mode_q[2:1] == 2'b01 && quiet_q > 4'h2 |-> ##[1:4] irq_out_n_oe)
    else $error("seconds write did not drive pulse low");
  a_clk_gated: assert property (gated && quiet_q > 4'h2 |-> !slow_clock_out_oe)
    else $error("slow clock driven while both gate bits set");
  a_clk_runs: assert property ((!gated && quiet_q > 4'h3 && $stable(osc_in)) [*4]
    |-> slow_clock_out_oe == !osc_in)
    else $error("slow clock does not follow oscillator");
  c_level_inc: cover property (mode_q == 3'h4 && sec_inc_q);
  c_gated: cover property (gated ##1 !gated);
  c_halt: cover property (stop);
endmodule
bind rtc_ctl rtc_ctl_checker #(.GATEABLE(GATEABLE)) rtc_ctl_checker_i (.clk, .rst, .ce,
  .osc_in, .osc_stopped, .reg_wr_stb_q, .reg_wr_addr_q, .reg_wr_data_q, .sec_inc_q,
  .adj_value, .test_mode, .slow_clock_out_oe, .irq_out_n_oe);

//--- tb/rtc_host.sv
`timescale 1ns/100ps
module rtc_host
#(
  parameter HALF = 8  // Serial half period in system cycles
)
(
  input  wire clk,
  input  wire so_o,
  output reg  ce,
  output reg  sclk,
  output reg  si
);
  // Frame closed, serial clock parked low between frames
  initial
  begin
    ce = 1'b0;
    sclk = 1'b0;
    si = 1'b0;
  end
  // One frame: command byte then one data byte, msb first
  task xfer(input [3:0] a, input rd, input [7:0] wd, output [7:0] rv);
    reg     [15:0] sh;
    integer        i;
    begin
      sh = {a, rd, 3'h0, wd};
      rv = 8'h00;
      @(negedge clk);
      ce = 1'b1;
      repeat (HALF) @(negedge clk);
      for (i = 0; i < 16; i = i + 1)
      begin
        si = sh[15 - i];
        repeat (HALF) @(negedge clk);
        sclk = 1'b1;
        if (i > 7)
          rv = {rv[6:0], so_o};  // Bit has stood since the previous rise
        repeat (HALF) @(negedge clk);
        sclk = 1'b0;
      end
      repeat (HALF) @(negedge clk);
      ce = 1'b0;
      si = ~si;  // Released line never keeps its last value
      repeat (HALF) @(negedge clk);
    end
  endtask
endmodule

//--- tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  localparam OSC = 64;        // Shortened oscillator count per second
  localparam SEC = OSC * 20;  // System cycles per second at 200 ns oscillator
  localparam DLY = 8;         // Shortened increment lag
  reg        clk, rst, osc_in, osc_stopped, supply_below_hi, supply_below_lo;
  reg        wrap_min, wrap_hour, wrap_month, last, adj_stretch, adj_shrink;
  reg  [7:0] ext_rd_data, rv, r;
  wire       ce, sclk, si, so_o, so_oe, reg_wr_stb_q, sec_inc_q, alarm_w_en, alarm_d_en;
  wire       hour_mode_24, test_mode, slow_clock_out_o, slow_clock_out_oe;
  wire       irq_out_n_o, irq_out_n_oe;
  wire [3:0] reg_wr_addr_q;
  wire [7:0] reg_wr_data_q;
  wire [6:0] adj_value;
  integer    bad_count, compares, cyc, n, m, k, t0, e;
  rtc_ctl #(.OSC_PER_S(OSC), .INC_DELAY(DLY)) rtc_ctl_i (.clk, .rst, .ce, .sclk, .si,
    .so_o, .so_oe, .osc_in, .osc_stopped, .supply_below_hi, .supply_below_lo,
    .adj_stretch, .adj_shrink, .wrap_min, .wrap_hour, .wrap_month,
    .alarm_w_hit(1'b0), .alarm_d_hit(1'b0), .ext_rd_data, .reg_wr_stb_q, .reg_wr_addr_q,
    .reg_wr_data_q, .sec_inc_q, .adj_value, .alarm_w_en, .alarm_d_en, .hour_mode_24,
    .test_mode, .slow_clock_out_o, .slow_clock_out_oe, .irq_out_n_o, .irq_out_n_oe);
  rtc_host rtc_host_i (.clk, .so_o, .ce, .sclk, .si);
  // System clock and an oscillator stepped on falling edges
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    osc_in = 1'b0;
    forever
    begin
      repeat (10) @(negedge clk);
      osc_in = ~osc_in;
    end
  end
  // Hang guard, well above the expected run length
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 80000)
    begin
      bad_count = bad_count + 1;
      report_and_stop;
    end
  end
  task chk(input [7:0] got, input [7:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp)
      begin
        bad_count = bad_count + 1;
        $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task flag(input got, input exp);
    chk({7'h0, got}, {7'h0, exp});
  endtask
  task wr(input [3:0] a, input [7:0] d);
    rtc_host_i.xfer(a, 1'b0, d, rv);
  endtask
  task rdchk(input [3:0] a, input [7:0] exp);
    begin
      rtc_host_i.xfer(a, 1'b1, 8'h00, rv);
      chk(rv, exp);
    end
  endtask
  // Wait for one increment, bounded by two seconds
  task wait_inc;
    begin
      n = 0;
      while (sec_inc_q !== 1'b1 && n < 2 * SEC)
      begin
        @(negedge clk);
        n = n + 1;
      end
      flag(sec_inc_q, 1'b1);
    end
  endtask
  // Count slow clock toggles over 200 cycles
  task toggles;
    begin
      n = 0;
      last = slow_clock_out_oe;
      repeat (200)
      begin
        @(negedge clk);
        n = n + (slow_clock_out_oe !== last);
        last = slow_clock_out_oe;
      end
    end
  endtask
  task t_reset;
    begin
      rdchk(4'hF, 8'h10);
      wr(4'hE, 8'h41);
      rdchk(4'hE, 8'h00);
      flag(irq_out_n_oe, 1'b0);
      chk({5'h0, so_oe, slow_clock_out_o, irq_out_n_o}, 8'h00);
      $display("reset test done");
    end
  endtask
  task t_regs;
    begin
      wr(4'hF, 8'h10);
      rdchk(4'hF, 8'h10);
      wr(4'hF, 8'h00);
      rdchk(4'hF, 8'h00);
      wr(4'hF, 8'h20);
      rdchk(4'hF, 8'h20);
      wr(4'hF, 8'h00);
      wr(4'hE, 8'hE0);  // Test bit kept clear
      chk({4'h0, alarm_w_en, alarm_d_en, hour_mode_24, test_mode}, 8'h0E);
      rdchk(4'hD, 8'hA5);
      $display("register test done");
    end
  endtask
  task t_pulse;
    begin
      for (k = 0; k < 2; k = k + 1)
      begin
        wr(4'hE, k[7:0]);
        flag(irq_out_n_oe, k[0]);
      end
      for (r = 8'h01; r < 8'h03; r = r + 8'h01)
      begin
        wr(4'hE, 8'h04 - r);
        wr(4'h0, 8'h00);
        {n, m, t0, last} = {32'd0, 32'd0, 32'd0, irq_out_n_oe};
        for (k = 0; k < 2000; k = k + 1)
        begin
          @(negedge clk);
          n = n + (last && !irq_out_n_oe);
          if (!last && irq_out_n_oe)
            t0 = k;
          if (sec_inc_q)
          begin
            m = m + 1;
            flag(k - t0 >= DLY - 1 && k - t0 <= DLY + 3, 1'b1);
          end
          last = irq_out_n_oe;
        end
        e = (2000 + SEC / (2 * r)) / (SEC / r);
        chk(n[7:0], e[7:0]);
        chk(m[7:0], 8'h01);
      end
      $display("pulse test done");
    end
  endtask
  task t_level;
    begin
      wr(4'hE, 8'h04);
      wait_inc;
      @(negedge clk);
      flag(irq_out_n_oe, 1'b1);
      rdchk(4'hF, 8'h04);
      wr(4'hF, 8'h00);
      flag(irq_out_n_oe, 1'b0);
      for (r = 8'h05; r < 8'h08; r = r + 8'h01)
      begin
        wr(4'hE, r);
        {wrap_month, wrap_hour, wrap_min} = 3'h0;
        wait_inc;
        repeat (3) @(negedge clk);
        flag(irq_out_n_oe, 1'b0);
        {wrap_month, wrap_hour, wrap_min} = 3'h1 << (r - 8'h05);
        wait_inc;
        repeat (3) @(negedge clk);
        flag(irq_out_n_oe, 1'b1);
        wr(4'hF, 8'h00);
      end
      {wrap_month, wrap_hour, wrap_min} = 3'h0;
      $display("level test done");
    end
  endtask
  task t_clkout;
    begin
      wr(4'hE, 8'h10);
      toggles;
      flag(n > 0, 1'b1);
      wr(4'hF, 8'h08);
      toggles;
      chk({n[6:0], slow_clock_out_oe}, 8'h00);
      wr(4'hE, 8'h00);
      toggles;
      flag(n > 0, 1'b1);
      wr(4'hF, 8'h00);
      $display("clock output test done");
    end
  endtask
  task t_supply;
    begin
      supply_below_hi = 1'b1;
      repeat (10) @(negedge clk);
      supply_below_hi = 1'b0;
      rdchk(4'hF, 8'h40);
      wr(4'hF, 8'h40);
      rdchk(4'hF, 8'h40);
      wr(4'hF, 8'h00);
      rdchk(4'hF, 8'h00);
      wr(4'hF, 8'h80);
      supply_below_hi = 1'b1;
      rdchk(4'hF, 8'h80);
      supply_below_lo = 1'b1;
      rdchk(4'hF, 8'hC0);
      {supply_below_hi, supply_below_lo} = 2'b00;
      wr(4'hF, 8'h80);
      rdchk(4'hF, 8'h80);
      $display("supply test done");
    end
  endtask
  task t_halt;
    begin
      wr(4'hE, 8'h11);
      wr(4'hF, 8'h88);
      wr(4'h7, 8'h35);
      chk({1'b0, adj_value}, 8'h35);
      fork
        rtc_host_i.xfer(4'hE, 1'b0, 8'h01, rv);
        begin
          repeat (60) @(negedge clk);
          osc_stopped = 1'b1;
          repeat (20) @(negedge clk);
          osc_stopped = 1'b0;
        end
      join
      rdchk(4'hE, 8'h01);
      osc_stopped = 1'b1;
      repeat (20) @(negedge clk);
      osc_stopped = 1'b0;
      rdchk(4'hF, 8'h10);  // Host polls the halt flag
      rdchk(4'hE, 8'h00);
      rdchk(4'h7, 8'h00);
      chk({7'h0, irq_out_n_oe}, 8'h00);
      toggles;
      flag(n > 0, 1'b1);
      $display("halt test done");
    end
  endtask
  // Stretch holds the divider, shrink nearly halves the second
  task t_adjust;
    begin
      for (k = 0; k < 2; k = k + 1)
      begin
        {adj_stretch, adj_shrink} = k[0] ? 2'b01 : 2'b10;
        wr(4'h0, 8'h00);
        m = 0;
        repeat (1500)
        begin
          @(negedge clk);
          m = m + sec_inc_q;
        end
        chk(m[7:0], k[0] ? 8'h02 : 8'h00);
      end
      {adj_stretch, adj_shrink} = 2'b00;
      $display("adjust test done");
    end
  endtask
  task report_and_stop;
    begin
      $display("comparisons %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  // Main sequence: reset, then each scenario in turn
  initial
  begin
    {rst, osc_stopped, supply_below_hi, supply_below_lo} = 4'h8;
    {wrap_min, wrap_hour, wrap_month} = 3'h0;
    {adj_stretch, adj_shrink} = 2'b00;
    {bad_count, compares, cyc} = 96'd0;
    ext_rd_data = 8'hA5;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    t_reset;
    t_regs;
    t_pulse;
    t_level;
    t_clkout;
    t_supply;
    t_adjust;
    t_halt;
    report_and_stop;
  end
endmodule
